/* hw/smc_pkg.sv */
// Constants, register map and types of the serial master block.
// Assumes one clock (pclk) and an APB slave port with 32-bit data.

package smc_pkg;

  // ==========================================================================
  // Register map (indices; byte address is four times the index)
  localparam int unsigned SMC_ADDR_W   = 8;
  localparam int unsigned SMC_IDX_CFG  = 'h29;
  localparam int unsigned SMC_IDX_CTL  = 'h2b;
  localparam int unsigned SMC_IDX_TX   = 'h2c;
  localparam int unsigned SMC_IDX_RX   = 'h2d;
  localparam logic [SMC_ADDR_W-1:0] SMC_ADDR_CFG = 8'(SMC_IDX_CFG * 4);
  localparam logic [SMC_ADDR_W-1:0] SMC_ADDR_CTL = 8'(SMC_IDX_CTL * 4);
  localparam logic [SMC_ADDR_W-1:0] SMC_ADDR_TX  = 8'(SMC_IDX_TX * 4);
  localparam logic [SMC_ADDR_W-1:0] SMC_ADDR_RX  = 8'(SMC_IDX_RX * 4);

  // ==========================================================================
  // Control register bit positions
  localparam int unsigned SMC_CTL_LSB_FIRST = 7;
  localparam int unsigned SMC_CTL_OVERRUN   = 6;
  localparam int unsigned SMC_CTL_COMPLETE  = 5;
  localparam int unsigned SMC_CTL_TX_EMPTY  = 4;
  localparam int unsigned SMC_CTL_RX_FULL   = 3;
  localparam int unsigned SMC_CTL_CPHA      = 2;
  localparam int unsigned SMC_CTL_CPOL      = 1;
  localparam int unsigned SMC_CTL_ENABLE    = 0;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0] SMC_CFG_RESET   = 8'h00;
  localparam logic [7:0] SMC_CTL_RESET   = 8'h00;
  localparam logic       SMC_MOSI_IDLE   = 1'b1;
  localparam logic [3:0] SMC_LAST_HALF   = 4'hf;
  localparam int unsigned SMC_FIRST_CLK_CYCLES = 2;

  // Configuration register as laid out in its byte
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       bypass;
    logic       ss_val;
    logic       ss_en_n;
    logic       int_sel;
    logic       slave;
  } smc_cfg_type;

  typedef enum logic [1:0] {
    SMC_IDLE = 2'b00,
    SMC_RUN  = 2'b01
  } smc_state_type;

endpackage : smc_pkg

/* hw/smc_clock_gen.sv */
// Serial clock divider with resynchronised tap.
// Assumes run is a synchronous level on pclk; counter is held at zero while low.
`timescale 1ns/1ps

module smc_clock_gen
  import smc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  output logic            half_tick
);

  logic [7:0] div_count;
  logic       tap_sync;
  logic       tap_prev;

  // ==========================================================================
  // Divider chain, held in reset while the block is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 8'h00;
    end else if (!run) begin
      div_count <= 8'h00;
    end else begin
      div_count <= div_count + 8'h01;
    end
  end

  // ==========================================================================
  // Tap resync; each tap change is one half serial period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_sync <= 1'b0;
      tap_prev <= 1'b0;
    end else if (!run) begin
      tap_sync <= 1'b0;
      tap_prev <= 1'b0;
    end else begin
      tap_sync <= div_count[clk_sel];
      tap_prev <= tap_sync;
    end
  end

  assign half_tick = run & (tap_sync ^ tap_prev);

endmodule // smc_clock_gen

/* hw/smc_spi_master.sv */
// Serial master block: APB register file, clock generation and shifter.
// Assumes APB master on pclk; miso and ss_pin_n come from pins.
`timescale 1ns/1ps

module smc_spi_master
  import smc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [SMC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  spi_miso,
  input  wire logic                  ss_pin_n,
  output logic                       spi_sclk,
  output logic                       spi_mosi,
  output logic                       slave_select_n,
  output logic                       spi_irq
);

  smc_cfg_type   cfg;
  logic [7:0]    ctl;
  logic [7:0]    transmit_buffer;
  logic [7:0]    receive_buffer;
  logic [7:0]    shift_data_reg;
  logic          tx_full;
  logic          rx_full;
  logic          complete;
  logic          overrun;
  logic          irq_armed;
  logic          sample_bit;
  logic          early_ok;
  smc_state_type state;
  logic [3:0]    half;
  logic [1:0]    miso_sync;
  logic [1:0]    ss_sync;
  logic          miso_in;
  logic          ss_in_n;
  logic          enable;
  logic          master_on;
  logic          tx_empty;
  logic          tick;
  logic          lead;
  logic          capture;
  logic          rx_load;
  logic          ovr_evt;
  logic          done_evt;
  logic          load_now;
  logic          setup;
  logic          access;
  logic          addr_ok;
  logic          wr_cfg;
  logic          wr_ctl;
  logic          wr_tx;
  logic          rd_ctl;
  logic          rd_rx;
  logic [3:0]    rx_half;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // APB decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign addr_ok = (paddr == SMC_ADDR_CFG) | (paddr == SMC_ADDR_CTL) |
                   (paddr == SMC_ADDR_TX) | (paddr == SMC_ADDR_RX);
  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign wr_cfg  = access & pwrite & (paddr == SMC_ADDR_CFG);
  assign wr_ctl  = access & pwrite & (paddr == SMC_ADDR_CTL);
  assign wr_tx   = access & pwrite & (paddr == SMC_ADDR_TX);
  assign rd_ctl  = access & ~pwrite & (paddr == SMC_ADDR_CTL);
  assign rd_rx   = access & ~pwrite & (paddr == SMC_ADDR_RX);

  assign enable    = ctl[SMC_CTL_ENABLE];
  assign master_on = enable & ~cfg.slave;
  assign tx_empty  = enable & ~tx_full;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        SMC_ADDR_CFG: prdata <= {24'h00_0000, cfg};
        SMC_ADDR_CTL: prdata <= {24'h00_0000, ctl[7], overrun, complete,
                                 tx_empty, rx_full, ctl[2:0]};
        SMC_ADDR_RX:  prdata <= {24'h00_0000, receive_buffer};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Configuration and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= smc_cfg_type'(SMC_CFG_RESET);
    end else if (wr_cfg && !enable) begin
      cfg <= smc_cfg_type'(pwdata[7:0]);
    end
  end

  // Only the writable bits are stored; status bits live in their own flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= SMC_CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= {pwdata[SMC_CTL_LSB_FIRST], 4'h0, pwdata[SMC_CTL_CPHA],
              pwdata[SMC_CTL_CPOL], pwdata[SMC_CTL_ENABLE]};
    end
  end

  // ==========================================================================
  // Pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_sync <= 2'b00;
      ss_sync   <= 2'b11;
    end else begin
      miso_sync <= {miso_sync[0], spi_miso};
      ss_sync   <= {ss_sync[0], ss_pin_n};
    end
  end

  assign miso_in = cfg.bypass ? spi_miso : miso_sync[1];
  assign ss_in_n = cfg.bypass ? ss_pin_n : ss_sync[1];

  // Resolved select level; only the slave role would act on it
  assign slave_select_n = cfg.ss_en_n ? ss_in_n : cfg.ss_val;

  // ==========================================================================
  // Clock generation
  smc_clock_gen u_clock_gen (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (master_on),
    .clk_sel   (cfg.clk_sel),
    .half_tick (tick)
  );

  // ==========================================================================
  // Edge classification; even half index is a leading edge
  assign lead     = ~half[0];
  assign capture  = (state == SMC_RUN) & tick & (lead ^ ctl[SMC_CTL_CPHA]);
  assign rx_half  = ctl[SMC_CTL_CPHA] ? SMC_LAST_HALF : SMC_LAST_HALF - 4'h1;
  assign rx_load  = capture & (half == rx_half);
  assign ovr_evt  = (state == SMC_RUN) & tick & (half == rx_half - 4'h1);
  assign done_evt = (state == SMC_RUN) & tick & (half == SMC_LAST_HALF);
  assign load_now = master_on & tx_full &
                    ((state == SMC_IDLE) | (done_evt & early_ok));

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // ==========================================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SMC_IDLE;
      half  <= 4'h0;
    end else if (!master_on) begin
      state <= SMC_IDLE;
      half  <= 4'h0;
    end else begin
      case (state)
        SMC_IDLE: begin
          half <= 4'h0;
          if (tx_full) begin
            state <= SMC_RUN;
          end
        end
        SMC_RUN: begin
          if (tick) begin
            half <= half + 4'h1;
            if (half == SMC_LAST_HALF && !load_now) begin
              state <= SMC_IDLE;
            end
          end
        end
        default: begin
          state <= SMC_IDLE;
          half  <= 4'h0;
        end
      endcase
    end
  end

  // Byte must already be waiting one half period before the last edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_ok <= 1'b0;
    end else if (!master_on) begin
      early_ok <= 1'b0;
    end else if (state == SMC_RUN && tick && half == SMC_LAST_HALF - 4'h1) begin
      early_ok <= tx_full;
    end
  end

  // ==========================================================================
  // Serial clock; holds the mode's idle level outside a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_sclk <= 1'b0;
    end else if (!master_on || state == SMC_IDLE) begin
      spi_sclk <= ctl[SMC_CTL_CPOL];
    end else if (tick) begin
      spi_sclk <= ~spi_sclk;
    end
  end

  // Data output is the shifter's end bit, idle high when off
  assign spi_mosi = !master_on ? SMC_MOSI_IDLE :
                    ctl[SMC_CTL_LSB_FIRST] ? shift_data_reg[0] :
                    shift_data_reg[7];

  // ==========================================================================
  // Data path; not cleared by disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer <= 8'h00;
    end else if (wr_tx) begin
      transmit_buffer <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_data_reg <= 8'h00;
      sample_bit     <= 1'b0;
    end else begin
      if (capture) begin
        sample_bit <= miso_in;
      end
      if (load_now) begin
        shift_data_reg <= transmit_buffer;
      end else if ((state == SMC_RUN) && tick && !capture && half != 4'h0 &&
                   half != SMC_LAST_HALF) begin
        shift_data_reg <= shift_in(shift_data_reg, sample_bit,
                                   ctl[SMC_CTL_LSB_FIRST]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer <= 8'h00;
    end else if (rx_load) begin
      receive_buffer <= shift_in(shift_data_reg, miso_in,
                                 ctl[SMC_CTL_LSB_FIRST]);
    end
  end

  // ==========================================================================
  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_full <= 1'b0;
    end else if (!enable) begin
      tx_full <= 1'b0;
    end else if (wr_tx) begin
      tx_full <= 1'b1;
    end else if (load_now) begin
      tx_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full <= 1'b0;
    end else if (!enable) begin
      rx_full <= 1'b0;
    end else if (rx_load) begin
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  // Only the value software actually saw is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete <= 1'b0;
      overrun  <= 1'b0;
    end else if (!enable) begin
      complete <= 1'b0;
      overrun  <= 1'b0;
    end else begin
      if (done_evt) begin
        complete <= 1'b1;
      end else if (rd_ctl && prdata[SMC_CTL_COMPLETE]) begin
        complete <= 1'b0;
      end
      if (ovr_evt && rx_full) begin
        overrun <= 1'b1;
      end else if (rd_ctl && prdata[SMC_CTL_OVERRUN]) begin
        overrun <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_armed <= 1'b0;
    end else if (!enable) begin
      irq_armed <= 1'b0;
    end else if (load_now) begin
      irq_armed <= 1'b1;
    end
  end

  assign spi_irq = cfg.int_sel ? complete : (tx_empty & irq_armed);

  // ==========================================================================
  // Checks
  a_tx_write_clears: assert property (wr_tx && enable |=> !tx_empty)
    else $error("transmit-empty stayed set after a transmit write");

  a_idle_start_load: assert property (master_on && state == SMC_IDLE && tx_full && !wr_tx
    |=> state == SMC_RUN && tx_empty)
    else $error("idle block did not load the shifter and start");

  a_back_to_back: assert property (master_on && done_evt && early_ok && tx_full
    |=> state == SMC_RUN && half == 4'h0)
    else $error("buffered byte did not start back to back");

  a_first_clock: assert property ($rose(master_on) && cfg.clk_sel == 3'h0
    |-> !tick ##SMC_FIRST_CLK_CYCLES tick)
    else $error("first serial clock not two cycles after enable");

  a_div_four: assert property (tick && master_on && cfg.clk_sel == 3'h1 && !wr_ctl ##1 !wr_ctl
    |-> !tick ##1 tick)
    else $error("divide-by-four tap spacing wrong");

  a_rx_full_set: assert property (rx_load && enable |=> rx_full && !$stable(receive_buffer)
    or rx_full)
    else $error("receive-full not set on eighth capture");

  a_complete_edge: assert property (done_evt && master_on
    |-> (rx_load == ctl[SMC_CTL_CPHA]) ##1 complete)
    else $error("transfer-complete timing against receive load wrong");

  a_overrun_set: assert property (ovr_evt && rx_full && enable
    |=> overrun ##1 (rx_load || !master_on || overrun))
    else $error("overrun not set before receive load");

  a_no_early_irq: assert property (!irq_armed && !cfg.int_sel |-> !spi_irq)
    else $error("transmit-empty interrupt fired before first load");

  a_disable_reset: assert property (!enable && !(wr_ctl && pwdata[SMC_CTL_ENABLE])
    |=> state == SMC_IDLE && !rx_full && !complete
    && spi_sclk == $past(ctl[SMC_CTL_CPOL]) && spi_mosi == SMC_MOSI_IDLE)
    else $error("disabled block not held idle");

  a_slave_halt: assert property (cfg.slave |=> state == SMC_IDLE)
    else $error("master engine ran in slave role");

  a_internal_select: assert property (!cfg.ss_en_n |-> slave_select_n == cfg.ss_val)
    else $error("internal select level not applied");

endmodule // smc_spi_master

/* bench/smc_slave_model.sv */
// External serial slave on the far side of the serial master.
// Assumes mode inputs mirror the master's control bits; a toggle of load arms a new byte.
`timescale 1ns/1ps

module smc_slave_model
  import smc_pkg::*;
(
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  input  wire logic       slave_select_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb_first,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            spi_miso,
  output logic [7:0]      rx_byte
);
  logic       miso_q;
  logic [3:0] out_cnt;

  function automatic logic pick(input logic [3:0] k);
    return lsb_first ? tx_byte[k[2:0]] : tx_byte[3'd7 - k[2:0]];
  endfunction

  initial begin
    miso_q  = 1'b0;
    out_cnt = 4'h0;
    rx_byte = 8'h00;
  end

  // Deselected line shows the inverse, never a stale bit
  assign spi_miso = slave_select_n ? ~miso_q : miso_q;

  // ==========================================================================
  // Shifting; wraps after eight bits so back-to-back bytes repeat the byte
  always @(load) begin
    out_cnt = cpha ? 4'h0 : 4'h1;
    miso_q  = cpha ? ~miso_q : pick(4'h0);
  end

  always @(spi_sclk) begin
    if ((spi_sclk !== cpol) ^ cpha) begin
      rx_byte = lsb_first ? {spi_mosi, rx_byte[7:1]} : {rx_byte[6:0], spi_mosi};
    end else begin
      miso_q  = pick(out_cnt);
      out_cnt = out_cnt + 4'h1;
    end
  end
endmodule // smc_slave_model

/* bench/tb_smc_spi_master.sv */
// Self-checking bench of the serial master: APB tasks and directed tests.
// Assumes the package register map and an APB slave that signals pready.
`timescale 1ns/1ps

module tb_smc_spi_master;
  import smc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ss_pin_n, spi_miso;
  logic [7:0]  paddr, rd, sl_tx, sl_rx;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, spi_sclk, spi_mosi, slave_select_n, spi_irq;
  logic        cpol, cpha, lsb, load, armed, sclk_q, err;
  smc_cfg_type cfg;
  int          fails, samples_checked, toggles, gap, max_gap, t0, k;
  logic [7:0]  txv [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  smc_spi_master dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_miso(spi_miso), .ss_pin_n(ss_pin_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .slave_select_n(slave_select_n), .spi_irq(spi_irq));

  smc_slave_model slave_u (.spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .slave_select_n(slave_select_n), .cpol(cpol), .cpha(cpha), .lsb_first(lsb),
    .load(load), .tx_byte(sl_tx), .spi_miso(spi_miso), .rx_byte(sl_rx));

  // ==========================================================================
  // Widest gap between serial clock changes, in pclk cycles
  always @(posedge pclk) begin
    gap = gap + 1;
    if (spi_sclk !== sclk_q) begin
      if (armed && gap > max_gap) max_gap = gap;
      armed   = 1'b1;
      toggles = toggles + 1;
      gap     = 0;
    end
    sclk_q = spi_sclk;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // No wait-state count assumed; the watchdog ends a hung access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Disable first: configuration only changes while disabled
  task automatic setup(input smc_cfg_type c, input logic [7:0] ctl);
    cpol = ctl[1];
    cpha = ctl[2];
    lsb  = ctl[7];
    apb(1'b1, SMC_ADDR_CTL, 8'h00);
    apb(1'b1, SMC_ADDR_CFG, c);
    apb(1'b1, SMC_ADDR_CTL, ctl);
  endtask

  task automatic send(input logic [7:0] b, input logic [7:0] s);
    sl_tx   = s;
    load    = ~load;
    armed   = 1'b0;
    max_gap = 0;
    apb(1'b1, SMC_ADDR_TX, b);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    stop_test;
  end

  // ==========================================================================
  // Tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, load, armed, sclk_q, cpol, cpha, lsb} = '0;
    {gap, max_gap, toggles, fails, samples_checked} = '0;
    ss_pin_n = 1'b1;
    sl_tx    = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SMC_ADDR_CFG, 8'h00);
    check("cfg reset", rd, 8'h00);
    apb(1'b0, SMC_ADDR_CTL, 8'h00);
    check("ctl reset", rd, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 8'h00);
    check("select reset", slave_select_n, 1'b0);
    apb(1'b1, SMC_ADDR_CFG, 8'h04);
    ss_pin_n <= 1'b0;
    // Two synchroniser flops lie between the pin and the select level
    repeat (3) @(posedge pclk);
    check("select pin low", slave_select_n, 1'b0);
    ss_pin_n <= 1'b1;
    repeat (3) @(posedge pclk);
    check("select pin high", slave_select_n, 1'b1);
    ss_pin_n <= 1'b0;
    apb(1'b1, SMC_ADDR_CFG, 8'h08);
    check("select bit high", slave_select_n, 1'b1);
    apb(1'b1, SMC_ADDR_CFG, 8'h00);
    check("select bit low", slave_select_n, 1'b0);
    $display("test select done");

    for (int m = 0; m < 4; m++) begin
      cfg = '{3'(m), 1'(m < 2), 1'b0, 1'b0, 1'(m % 2), 1'b0};
      setup(cfg, {1'(m % 2 != m / 2), 4'h0, 1'(m / 2), 1'(m % 2), 1'b1});
      // Clock flop takes the new idle level one edge after the enable write
      @(posedge pclk);
      check("sclk idle", spi_sclk, cpol);
      check("irq at enable", spi_irq, 1'b0);
      apb(1'b0, SMC_ADDR_CTL, 8'h00);
      check("tx empty", rd[4], 1'b1);
      send(txv[m], ~txv[m]);
      k = 0;
      do begin
        apb(1'b0, SMC_ADDR_CTL, 8'h00);
        k++;
      end while (rd[5] !== 1'b1 && k < 300);
      check("ctl done", rd, {lsb, 4'b0111, cpha, cpol, 1'b1});
      check("irq source", spi_irq, 1'(m % 2 == 0));
      apb(1'b0, SMC_ADDR_CTL, 8'h00);
      check("complete cleared", rd[5], 1'b0);
      apb(1'b0, SMC_ADDR_RX, 8'h00);
      check("rx byte", rd, 8'(~txv[m]));
      apb(1'b0, SMC_ADDR_CTL, 8'h00);
      check("rx full cleared", rd[3], 1'b0);
      check("slave got", sl_rx, txv[m]);
      check("half period", max_gap, 1 << m);
      check("sclk back idle", spi_sclk, cpol);
      $display("test mode %0d done", m);
    end

    setup('{3'd1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 8'h01);
    t0 = toggles;
    send(8'h11, 8'h5a);
    apb(1'b1, SMC_ADDR_TX, 8'h22);
    apb(1'b0, SMC_ADDR_CTL, 8'h00);
    check("tx held", rd[4], 1'b0);
    apb(1'b1, SMC_ADDR_CFG, 8'hff);
    apb(1'b0, SMC_ADDR_CFG, 8'h00);
    check("cfg locked", rd, 8'h30);
    k = 0;
    while (toggles - t0 < 32 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    check("two bytes clocked", k < 2000, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, SMC_ADDR_CTL, 8'h00);
    check("overrun", rd[6], 1'b1);
    check("no gap", max_gap, 2);
    check("slave second", sl_rx, 8'h22);
    $display("test back to back done");

    apb(1'b1, SMC_ADDR_CTL, 8'h00);
    check("mosi idle", spi_mosi, SMC_MOSI_IDLE);
    check("sclk idle off", spi_sclk, 1'b0);
    apb(1'b0, SMC_ADDR_CTL, 8'h00);
    check("status reset", rd, 8'h00);
    apb(1'b0, SMC_ADDR_RX, 8'h00);
    check("rx kept", rd, 8'h5a);
    $display("test disable done");

    setup('{3'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1}, 8'h01);
    t0 = toggles;
    apb(1'b1, SMC_ADDR_TX, 8'h33);
    repeat (64) @(posedge pclk);
    check("slave role quiet", toggles - t0, 0);
    $display("test slave role done");
    stop_test;
  end
endmodule // tb_smc_spi_master
